/* File: design/cie_defines.vh */
// Shared constants for the instruction subset execution block.
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH
`define CIE_Q1          2'h0
`define CIE_Q2          2'h1
`define CIE_Q3          2'h2
`define CIE_Q4          2'h3
`define CIE_OP_ADDC     6'h08
`define CIE_OP_RRNC     6'h10
`define CIE_OP_FILL_ONES_TO_FILE     7'h34
`define CIE_OP_ANDL     8'h0b
`define CIE_OP_PUSH     8'hea
`define CIE_OP_COPY1    9'h1d7
`define CIE_OP_COPY2    4'hf
`define CIE_D_BIT       9
`define CIE_A_BIT       8
`define CIE_ACC_SPLIT   8'h60
`define CIE_SFR_PAGE    4'hf
`define CIE_SFR_BASE    12'hf60
`define CIE_A_ACCUM     12'hfe8
`define CIE_A_STATUS    12'hfd8
`define CIE_A_PTR_LO    12'hfd9
`define CIE_A_PTR_HI    12'hfda
`define CIE_A_BANK      12'hfe0
`define CIE_A_TIMER     12'hfd6
`define CIE_A_PORT      12'hf81
`define CIE_A_PCL       12'hff9
`define CIE_A_STACK_TOP_LOW      12'hffd
`define CIE_A_STACK_TOP_HIGH      12'hffe
`define CIE_A_STACK_TOP_UPPER      12'hfff
`define CIE_IND0_BASE   12'hfeb
`define CIE_IND1_BASE   12'hfe3
`define CIE_IND2_BASE   12'hfdb
`define CIE_IND_SPAN    12'h005
`define CIE_F_C         0
`define CIE_F_DC        1
`define CIE_F_Z         2
`define CIE_F_OV        3
`define CIE_F_N         4
`define CIE_FILL        8'hff
`define CIE_SRC_IND_VAL 8'h00
`define CIE_R_CTRL      8'h00
`define CIE_R_ACCUM     8'h04
`define CIE_R_FLAGS     8'h08
`define CIE_R_PTR       8'h0c
`define CIE_R_TMRBANK   8'h10
`define CIE_R_PC        8'h14
`define CIE_R_MEMADDR   8'h18
`define CIE_R_MEMDATA   8'h1c
`define CIE_RESP_OK     2'h0
`define CIE_RESP_ERR    2'h2
`define CIE_CTRL_RUN    0
`define CIE_CTRL_PSA    1
`define CIE_RST_CTRL    5'h00
`endif

/* File: design/cie_dpram.v */
// Two-port byte memory with registered read data on both ports.
module cie_dpram #(
    parameter AW = 12,
    parameter DW = 8
) (
    // Clock
    input  wire          clk,
    // Core port
    input  wire [AW-1:0] a_addr,
    input  wire          a_we,
    input  wire [DW-1:0] a_wdata,
    output reg  [DW-1:0] a_rdata,
    // Bus port
    input  wire [AW-1:0] b_addr,
    input  wire          b_we,
    input  wire [DW-1:0] b_wdata,
    output reg  [DW-1:0] b_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // One process owns the array; when both ports write one byte in the same edge, the bus port wins.
    always @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule

/* File: design/cie_exec.v */
// Instruction subset decode and execute core with data memory and register slave.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`include "cie_defines.vh"

// What this block does
// - Port read-modify-write reads the pin levels, not the output latch.
// - Writing the timer count clears its prescaler when the prescaler is assigned.
// - Program counter change costs two cycles; the second runs as no-operation.
// - A lone second word of a two-word instruction runs as no-operation.
// - Add-with-carry sums accumulator, file, carry; d picks destination; five flags.
// - AND literal into accumulator, one cycle, updates negative and zero only.
// - Fill-ones writes all ones to the file, flags untouched, one cycle.
// - Indexed copy adds two 7-bit offsets to pointer; copies; flags untouched.
// - Both computed copy addresses cover the whole 4096-byte data space.
// - Indexed copy never writes program counter low or stack top bytes.
// - Indexed copy source on an indirect register reads zero.
// - Indexed copy destination on an indirect register writes nothing.
// - Indexed copy spans two words and two cycles, second word carries destination.
// - Push literal stores at pointer address, then decrements pointer, one cycle.
module cie_exec #(
    parameter AW = 12
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST,
    // Instruction fetch
    input  wire [15:0] INSTR_WORD,
    input  wire        INSTR_VALID,
    output wire        INSTR_READY,
    output wire [15:0] PC_OUT,
    // Port pins
    input  wire [7:0]  PORT_PINS,
    output wire [7:0]  PORT_LATCH,
    // AXI4-Lite slave
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output wire [1:0]  S_AXI_BRESP,
    output wire        S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0]  S_AXI_RRESP,
    output wire        S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    localparam OP_NOP   = 3'h0;
    localparam OP_ADDC  = 3'h1;
    localparam OP_ANDL  = 3'h2;
    localparam OP_RRNC  = 3'h3;
    localparam OP_FILL_ONES_TO_FILE  = 3'h4;
    localparam OP_COPY1 = 3'h5;
    localparam OP_COPY2 = 3'h6;
    localparam OP_PUSH  = 3'h7;

    reg  [1:0]    q_ff;
    reg  [2:0]    op_ff;
    reg  [15:0]   ir_ff;
    reg           pend_ff;
    reg           flush_ff;
    reg  [15:0]   pc_ff;
    reg  [7:0]    acc_ff;
    reg  [4:0]    flags_ff;
    reg  [11:0]   ptr_ff;
    reg  [3:0]    bank_ff;
    reg  [7:0]    timer_ff;
    reg  [7:0]    pre_ff;
    reg  [7:0]    latch_ff;
    reg  [7:0]    pins_s1_ff;
    reg  [7:0]    pins_s2_ff;
    reg  [7:0]    sfr_q_ff;
    reg           src_sfr_ff;
    reg  [7:0]    res_ff;
    reg  [4:0]    nflags_ff;
    reg  [7:0]    copy_ff;
    reg  [4:0]    ctrl_ff;
    reg  [AW-1:0] memaddr_ff;
    reg           aw_held_ff;
    reg  [7:0]    awaddr_ff;
    reg           w_held_ff;
    reg  [31:0]   wdata_ff;
    reg  [3:0]    wstrb_ff;
    reg           bvalid_ff;
    reg  [1:0]    bresp_ff;
    reg           rvalid_ff;
    reg  [31:0]   rdata_ff;
    reg  [1:0]    rresp_ff;

    reg  [11:0]   file_addr;
    reg  [11:0]   eff;
    reg  [7:0]    sfr_rd;
    reg  [2:0]    dec_op;
    reg  [7:0]    nxt_res;
    reg  [4:0]    nxt_flags;
    reg           wr_file;
    reg           wr_acc;
    reg  [31:0]   rd_word;
    reg           rd_ok;

    wire          run      = ctrl_ff[`CIE_CTRL_RUN];
    wire          psa      = ctrl_ff[`CIE_CTRL_PSA];
    wire [2:0]    ps_sel   = ctrl_ff[4:2];
    wire          take     = INSTR_VALID && INSTR_READY;
    wire          d_bit    = ir_ff[`CIE_D_BIT];
    wire [7:0]    ram_q;
    wire [7:0]    bus_q;
    wire [7:0]    opnd     = src_sfr_ff ? sfr_q_ff : ram_q;
    wire          is_sfr   = eff >= `CIE_SFR_BASE;
    wire          is_ind   = ((eff - `CIE_IND0_BASE) < `CIE_IND_SPAN) ||
                             ((eff - `CIE_IND1_BASE) < `CIE_IND_SPAN) ||
                             ((eff - `CIE_IND2_BASE) < `CIE_IND_SPAN);
    wire          is_prot  = (eff == `CIE_A_PCL) || (eff == `CIE_A_STACK_TOP_LOW) ||
                             (eff == `CIE_A_STACK_TOP_HIGH) || (eff == `CIE_A_STACK_TOP_UPPER);
    wire          wr_now   = run && (q_ff == `CIE_Q4);
    wire          wr_ram   = wr_now && wr_file && !is_sfr;
    wire          wr_sfr   = wr_now && wr_file && is_sfr;
    wire [7:0]    pre_mask = (8'h02 << ps_sel) - 8'h01;
    wire          tmr_tick = !psa || ((pre_ff & pre_mask) == pre_mask);
    wire          do_wr    = aw_held_ff && w_held_ff && !bvalid_ff;
    wire [7:0]    wr_reg   = {awaddr_ff[7:2], 2'h0};

    assign INSTR_READY   = run && (q_ff == `CIE_Q1);
    assign PC_OUT        = pc_ff;
    assign PORT_LATCH    = latch_ff;
    assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
    assign S_AXI_WREADY  = !w_held_ff && !bvalid_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;

    // Pins are asynchronous to the core clock.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pins_s1_ff <= 8'h00;
            pins_s2_ff <= 8'h00;
        end else begin
            pins_s1_ff <= PORT_PINS;
            pins_s2_ff <= pins_s1_ff;
        end
    end

    always @* begin
        if (ir_ff[`CIE_A_BIT]) begin
            file_addr = {bank_ff, ir_ff[7:0]};
        end else if (ir_ff[7:0] < `CIE_ACC_SPLIT) begin
            file_addr = {4'h0, ir_ff[7:0]};
        end else begin
            file_addr = {`CIE_SFR_PAGE, ir_ff[7:0]};
        end
        case (op_ff)
            OP_COPY1, OP_COPY2: eff = ptr_ff + {5'h00, ir_ff[6:0]};
            OP_PUSH:            eff = ptr_ff;
            default:            eff = file_addr;
        endcase
    end

    always @* begin
        case (eff)
            `CIE_A_ACCUM:  sfr_rd = acc_ff;
            `CIE_A_STATUS: sfr_rd = {3'h0, flags_ff};
            `CIE_A_PTR_LO: sfr_rd = ptr_ff[7:0];
            `CIE_A_PTR_HI: sfr_rd = {4'h0, ptr_ff[11:8]};
            `CIE_A_BANK:   sfr_rd = {4'h0, bank_ff};
            `CIE_A_TIMER:  sfr_rd = timer_ff;
            `CIE_A_PORT:   sfr_rd = pins_s2_ff;
            `CIE_A_PCL:    sfr_rd = pc_ff[7:0];
            default:       sfr_rd = 8'h00;
        endcase
    end

    always @* begin
        dec_op = OP_NOP;
        if (INSTR_WORD[15:10] == `CIE_OP_ADDC) begin
            dec_op = OP_ADDC;
        end else if (INSTR_WORD[15:8] == `CIE_OP_ANDL) begin
            dec_op = OP_ANDL;
        end else if (INSTR_WORD[15:10] == `CIE_OP_RRNC) begin
            dec_op = OP_RRNC;
        end else if (INSTR_WORD[15:9] == `CIE_OP_FILL_ONES_TO_FILE) begin
            dec_op = OP_FILL_ONES_TO_FILE;
        end else if (INSTR_WORD[15:7] == `CIE_OP_COPY1) begin
            dec_op = OP_COPY1;
        end else if (INSTR_WORD[15:8] == `CIE_OP_PUSH) begin
            dec_op = OP_PUSH;
        end
        if (INSTR_WORD[15:12] == `CIE_OP_COPY2) begin
            dec_op = OP_NOP;
        end
    end

    // Quarter three: process data.
    always @* begin
        nxt_res   = 8'h00;
        nxt_flags = flags_ff;
        case (op_ff)
            OP_ADDC: begin
                {nxt_flags[`CIE_F_C], nxt_res} = {1'b0, acc_ff} + {1'b0, opnd} + {8'h00, flags_ff[`CIE_F_C]};
                nxt_flags[`CIE_F_DC] = ({1'b0, acc_ff[3:0]} + {1'b0, opnd[3:0]} +
                                        {4'h0, flags_ff[`CIE_F_C]}) > 5'h0f;
                nxt_flags[`CIE_F_OV] = (acc_ff[7] == opnd[7]) && (nxt_res[7] != acc_ff[7]);
                nxt_flags[`CIE_F_N]  = nxt_res[7];
                nxt_flags[`CIE_F_Z]  = nxt_res == 8'h00;
            end
            OP_ANDL: begin
                nxt_res = acc_ff & ir_ff[7:0];
                nxt_flags[`CIE_F_N] = nxt_res[7];
                nxt_flags[`CIE_F_Z] = nxt_res == 8'h00;
            end
            OP_RRNC: begin
                nxt_res = {opnd[0], opnd[7:1]};
                nxt_flags[`CIE_F_N] = nxt_res[7];
                nxt_flags[`CIE_F_Z] = nxt_res == 8'h00;
            end
            OP_FILL_ONES_TO_FILE:  nxt_res = `CIE_FILL;
            OP_PUSH:  nxt_res = ir_ff[7:0];
            OP_COPY2: nxt_res = copy_ff;
            default:  nxt_res = 8'h00;
        endcase
    end

    always @* begin
        wr_file = 1'b0;
        wr_acc  = 1'b0;
        case (op_ff)
            OP_ADDC, OP_RRNC: begin
                wr_file = d_bit;
                wr_acc  = !d_bit;
            end
            OP_ANDL:          wr_acc  = 1'b1;
            OP_FILL_ONES_TO_FILE, OP_PUSH: wr_file = 1'b1;
            OP_COPY2:         wr_file = !is_ind && !is_prot;
            default:          wr_file = 1'b0;
        endcase
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            q_ff       <= `CIE_Q1;
            op_ff      <= OP_NOP;
            ir_ff      <= 16'h0000;
            pend_ff    <= 1'b0;
            flush_ff   <= 1'b0;
            pc_ff      <= 16'h0000;
            sfr_q_ff   <= 8'h00;
            src_sfr_ff <= 1'b0;
            res_ff     <= 8'h00;
            nflags_ff  <= 5'h00;
            copy_ff    <= 8'h00;
        end else if (run) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
                `CIE_Q1: begin
                    if (take) begin
                        pc_ff <= pc_ff + 16'h0001;
                        ir_ff <= INSTR_WORD;
                    end
                    if (flush_ff) begin
                        op_ff    <= OP_NOP;
                        flush_ff <= 1'b0;
                        pend_ff  <= 1'b0;
                    end else if (pend_ff) begin
                        op_ff   <= take ? OP_COPY2 : OP_NOP;
                        pend_ff <= !take;
                    end else begin
                        op_ff   <= take ? dec_op : OP_NOP;
                        pend_ff <= take && (dec_op == OP_COPY1);
                    end
                end
                `CIE_Q2: begin
                    sfr_q_ff   <= sfr_rd;
                    src_sfr_ff <= is_sfr;
                end
                `CIE_Q3: begin
                    res_ff    <= nxt_res;
                    nflags_ff <= nxt_flags;
                    if (op_ff == OP_COPY1) begin
                        copy_ff <= is_ind ? `CIE_SRC_IND_VAL : opnd;
                    end
                end
                default: begin
                    if (wr_sfr && (eff == `CIE_A_PCL)) begin
                        pc_ff    <= {pc_ff[15:8], res_ff};
                        flush_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Quarter four: special register write-back; flag results override a status write.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            acc_ff   <= 8'h00;
            flags_ff <= 5'h00;
            ptr_ff   <= 12'h000;
            bank_ff  <= 4'h0;
            timer_ff <= 8'h00;
            pre_ff   <= 8'h00;
            latch_ff <= 8'h00;
        end else if (wr_now) begin
            pre_ff <= pre_ff + 8'h01;
            if (tmr_tick) begin
                timer_ff <= timer_ff + 8'h01;
            end
            if (wr_sfr) begin
                case (eff)
                    `CIE_A_ACCUM:  acc_ff   <= res_ff;
                    `CIE_A_STATUS: flags_ff <= res_ff[4:0];
                    `CIE_A_PTR_LO: ptr_ff   <= {ptr_ff[11:8], res_ff};
                    `CIE_A_PTR_HI: ptr_ff   <= {res_ff[3:0], ptr_ff[7:0]};
                    `CIE_A_BANK:   bank_ff  <= res_ff[3:0];
                    `CIE_A_PORT:   latch_ff <= res_ff;
                    `CIE_A_TIMER: begin
                        timer_ff <= res_ff;
                        if (psa) begin
                            pre_ff <= 8'h00;
                        end
                    end
                    default: ;
                endcase
            end
            if (wr_acc) begin
                acc_ff <= res_ff;
            end
            if (op_ff == OP_ADDC || op_ff == OP_ANDL || op_ff == OP_RRNC) begin
                flags_ff <= nflags_ff;
            end
            if (op_ff == OP_PUSH) begin
                ptr_ff <= ptr_ff - 12'h001;
            end
        end
    end

    // Register bus: write address and data are held independently until both are present.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 8'h00;
            w_held_ff  <= 1'b0;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CIE_RESP_OK;
            ctrl_ff    <= `CIE_RST_CTRL;
            memaddr_ff <= {AW{1'b0}};
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= S_AXI_WDATA;
                wstrb_ff  <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= `CIE_RESP_OK;
                case (wr_reg)
                    `CIE_R_CTRL: if (wstrb_ff[0]) ctrl_ff <= wdata_ff[4:0];
                    `CIE_R_MEMADDR: begin
                        if (wstrb_ff[0]) memaddr_ff[7:0] <= wdata_ff[7:0];
                        if (wstrb_ff[1]) memaddr_ff[AW-1:8] <= wdata_ff[AW-1:8];
                    end
                    `CIE_R_MEMDATA, `CIE_R_ACCUM, `CIE_R_FLAGS, `CIE_R_PTR,
                    `CIE_R_TMRBANK, `CIE_R_PC: bresp_ff <= `CIE_RESP_OK;
                    default: bresp_ff <= `CIE_RESP_ERR;
                endcase
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always @* begin
        rd_ok = 1'b1;
        case ({S_AXI_ARADDR[7:2], 2'h0})
            `CIE_R_CTRL:    rd_word = {27'h0, ctrl_ff};
            `CIE_R_ACCUM:   rd_word = {24'h0, acc_ff};
            `CIE_R_FLAGS:   rd_word = {27'h0, flags_ff};
            `CIE_R_PTR:     rd_word = {20'h0, ptr_ff};
            `CIE_R_TMRBANK: rd_word = {20'h0, bank_ff, timer_ff};
            `CIE_R_PC:      rd_word = {16'h0, pc_ff};
            `CIE_R_MEMADDR: rd_word = {{(32-AW){1'b0}}, memaddr_ff};
            `CIE_R_MEMDATA: rd_word = {24'h0, bus_q};
            default: begin
                rd_word = 32'h00000000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `CIE_RESP_OK;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_ok ? `CIE_RESP_OK : `CIE_RESP_ERR;
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Bus writes to memory are meant for preloading while the core is stopped.
    cie_dpram #(
        .AW (AW),
        .DW (8)
    ) u_mem (
        .clk     (CORE_CLK),
        .a_addr  (eff[AW-1:0]),
        .a_we    (wr_ram),
        .a_wdata (res_ff),
        .a_rdata (ram_q),
        .b_addr  (memaddr_ff),
        .b_we    (do_wr && (wr_reg == `CIE_R_MEMDATA) && wstrb_ff[0]),
        .b_wdata (wdata_ff[7:0]),
        .b_rdata (bus_q)
    );
endmodule

/* File: tb/cie_exec_checker.sv */
// Port-level assertions for the instruction subset execution block.
module cie_exec_checker (
    // Clock and reset
    input logic        CORE_CLK,
    input logic        RST,
    // Fetch
    input logic        INSTR_VALID,
    input logic        INSTR_READY,
    input logic [15:0] PC_OUT,
    // Register bus
    input logic        S_AXI_AWVALID,
    input logic        S_AXI_AWREADY,
    input logic        S_AXI_WVALID,
    input logic        S_AXI_WREADY,
    input logic [1:0]  S_AXI_BRESP,
    input logic        S_AXI_BVALID,
    input logic        S_AXI_BREADY,
    input logic        S_AXI_ARVALID,
    input logic        S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic [1:0]  S_AXI_RRESP,
    input logic        S_AXI_RVALID,
    input logic        S_AXI_RREADY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    chk_fetch_spacing: assert property (INSTR_READY |=> !INSTR_READY [*3])
        else $error("fetch slot repeated within one instruction cycle");
    chk_pc_step: assert property (INSTR_READY && INSTR_VALID |=> PC_OUT == $past(PC_OUT) + 16'h1)
        else $error("program counter did not step by one word");
    chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped before handshake");
    chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)
        && $stable(S_AXI_RRESP))
        else $error("read data dropped before handshake");
    chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##2 S_AXI_BVALID)
        else $error("write answer late");
    chk_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    chk_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while data pending");
    cov_fetch: cover property (INSTR_READY && INSTR_VALID);
    cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    cov_slverr: cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == 2'h2);
endmodule

/* File: tb/cie_prog_mem.sv */
// Program memory model that offers the word at the fetch address.
module cie_prog_mem (
    // Clock
    input  logic        clk,
    // Fetch side
    input  logic [15:0] pc,
    input  logic        stall,
    output logic        valid,
    output logic [15:0] word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] progw [0:31];
    initial begin
        valid = 1'b0;
        word = 16'h0;
    end
    // A stalled slot scrambles the word, so taking it by mistake shows up.
    always @(posedge clk) begin
        valid <= !stall;
        word <= stall ? ~word : progw[pc[4:0]];
    end
endmodule

/* File: tb/cie_exec_tb.sv */
// Self-checking bench for the instruction subset execution block.
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module cie_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, ivalid, iready, awvalid, awready, wvalid, wready;
    logic        stall = 1'b0;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] iword, pc;
    logic [7:0]  pins, latch, awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [11:0] ma [3] = '{12'hf5e, 12'hf5f, 12'h040};
    logic [7:0]  me [3] = '{8'h33, 8'h00, 8'hff};
    int          failures = 0, checked = 0, cyc = 0;
    cie_exec dut_u (.CORE_CLK(clk), .RST(rst), .INSTR_WORD(iword), .INSTR_VALID(ivalid), .INSTR_READY(iready),
        .PC_OUT(pc), .PORT_PINS(pins), .PORT_LATCH(latch), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    cie_prog_mem prog_u (.clk(clk), .pc(pc), .stall(stall), .valid(ivalid), .word(iword));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic conclude;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Stalling every other fetch slot also parts the two words of a copy.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        stall <= cyc[2];
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tr;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        `CMP(r, 2'h0)
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        pins = 8'h5a;
        prog_u.progw = '{0: 16'h68e8, 1: 16'h68d8, 2: 16'h68d9, 3: 16'h68da, 4: 16'h0b5f, 5: 16'hf0ff,
            6: 16'h22d9, 7: 16'hea33, 8: 16'h4281, 9: 16'h4030, 10: 16'heb81, 11: 16'hf000,
            12: 16'hebfd, 13: 16'hf001, 14: 16'h6840, 16: 16'h68d6, default: 16'h0000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wr(8'h18, 32'h30);
        wr(8'h1c, 32'h01);
        // Prescaler assigned to the timer, one tick every fourth instruction cycle.
        wr(8'h00, 32'h7);
        while (pc !== 16'h0011) @(negedge clk);
        repeat (8) @(posedge clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        `CMP(d[7:0], 8'h80)
        rd(8'h08);
        `CMP(d[4:0], 5'h13)
        rd(8'h0c);
        `CMP(d[11:0], 12'hf5e)
        `CMP(latch, 8'h2d)
        // The timer write cleared the prescaler, so the two cycles that follow bring no tick.
        rd(8'h10);
        `CMP(d[11:0], 12'h0ff)
        foreach (ma[i]) begin
            wr(8'h18, {20'h0, ma[i]});
            repeat (2) @(posedge clk);
            rd(8'h1c);
            `CMP(d[7:0], me[i])
        end
        rd(8'h20);
        `CMP(r, 2'h2)
        `CMP(d, 32'h0)
        conclude();
    end
endmodule
bind cie_exec cie_exec_checker chk_u (.CORE_CLK, .RST, .INSTR_VALID, .INSTR_READY, .PC_OUT, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
